// >>> vifs_pkg.sv
package vifs_pkg;

    // apb geometry
    localparam int          ADDR_W         = 12;
    localparam int          DATA_W         = 32;
    localparam int          IDX_W          = 8;

    // register indices as printed; byte address is four times the index
    localparam logic [7:0]  IDX_ASPECT     = 8'h82;
    localparam logic [7:0]  IDX_SCALING    = 8'h83;
    localparam logic [7:0]  IDX_VFC        = 8'h84;
    localparam logic [7:0]  IDX_REPEAT     = 8'h85;
    localparam logic [7:0]  IDX_TOPBAR_LO  = 8'h86;
    localparam logic [7:0]  IDX_FLAGS_A    = 8'h87;
    localparam logic [7:0]  IDX_TOPBAR_HI  = 8'h88;
    localparam logic [7:0]  IDX_FLAGS_B    = 8'h8F;
    localparam logic [7:0]  IDX_IRQ_STATUS = 8'hF0;
    localparam logic [7:0]  IDX_IRQ_MASK   = 8'hF1;

    // field widths
    localparam int          ASPECT_W       = 4;
    localparam int          SCALING_W      = 2;
    localparam int          VFC_W          = 7;
    localparam int          REPEAT_W       = 4;
    localparam int          TOPBAR_W       = 16;
    localparam int          FLAG_W         = 7;

    // change flag bit positions
    localparam int          FLG_AVI        = 0;
    localparam int          FLG_AUDIO      = 1;
    localparam int          FLG_SPD        = 2;
    localparam int          FLG_MPEG       = 3;
    localparam int          FLG_ACP        = 4;
    localparam int          FLG_ISRC1      = 5;
    localparam int          FLG_ISRC2      = 6;

    // active format aspect codes
    localparam logic [3:0]  AFA_SAME       = 4'h8;
    localparam logic [3:0]  AFA_4_3        = 4'h9;
    localparam logic [3:0]  AFA_16_9       = 4'hA;
    localparam logic [3:0]  AFA_14_9       = 4'hB;

    // scaling codes
    localparam logic [1:0]  SC_NONE        = 2'h0;
    localparam logic [1:0]  SC_HORIZ       = 2'h1;
    localparam logic [1:0]  SC_VERT        = 2'h2;
    localparam logic [1:0]  SC_BOTH        = 2'h3;

    // reset values
    localparam logic [6:0]  FLAGS_RST      = 7'h00;
    localparam logic [6:0]  MASK_RST       = 7'h00;
    localparam logic [15:0] TOPBAR_NONE    = 16'h0000;

endpackage : vifs_pkg

// >>> vifs_regs.sv
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps

// Contract
// - report four-bit active format aspect code
// - two-bit scaling code at 0x83
// - seven-bit video format code at 0x84
// - repetition field at 0x85, count minus one
// - top-bar end line, 0x86 low, 0x88 high
// - top-bar end line zero means no bar
// - seven change flags at 0x87 set on change
// - flags read 0x00 when nothing changed
// - reading any flag copy clears all flags; the code clears only the bits that read returned
// - bits 0..2: avi, audio, spd infoframes
// - bits 3..6: mpeg, acp, isrc1, isrc2
// - second flag copy readable at 0x8F
module vifs_regs (
    input  wire logic        CLK_SYS_I,
    input  wire logic        RESET_N_I,
    // apb slave
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [11:0] PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    // decoded infoframe fields from the receiver, same clock
    input  wire logic [3:0]  ASPECT_CODE_I,
    input  wire logic [1:0]  SCALING_CODE_I,
    input  wire logic [6:0]  VIDEO_FORMAT_CODE_I,
    input  wire logic [3:0]  REPETITION_COUNT_I,
    input  wire logic [15:0] TOP_BAR_END_LINE_I,
    // one-cycle pulse per packet type whose content changed
    input  wire logic [6:0]  PACKET_CHANGED_I,
    output logic             IRQ_O
);

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        irq;
        logic [6:0]  irq_mask;
        logic [3:0]  aspect;
        logic [1:0]  scaling;
        logic [6:0]  vfc;
        logic [3:0]  repeat_cnt;
        logic [15:0] topbar;
    } vifs_state_t;

    vifs_state_t st_q;
    vifs_state_t st_d;

    logic [6:0] change_flags;
    logic [6:0] irq_status;
    // clears act at the completion edge itself, so a change sampled at
    // that same edge meets the clear inside the sticky set and wins
    logic [6:0] flag_clr;
    logic [6:0] stat_clr;

    // word index of an aligned, in-range address
    function automatic logic [7:0] addr_index(input logic [11:0] a);
        addr_index = a[9:2];
    endfunction

    function automatic logic addr_ok(input logic [11:0] a);
        logic [7:0] i;
        i = a[9:2];
        addr_ok = (a[1:0] == 2'h0) && (a[11:10] == 2'h0) &&
                  ((i == vifs_pkg::IDX_ASPECT)     ||
                   (i == vifs_pkg::IDX_SCALING)    ||
                   (i == vifs_pkg::IDX_VFC)        ||
                   (i == vifs_pkg::IDX_REPEAT)     ||
                   (i == vifs_pkg::IDX_TOPBAR_LO)  ||
                   (i == vifs_pkg::IDX_FLAGS_A)    ||
                   (i == vifs_pkg::IDX_TOPBAR_HI)  ||
                   (i == vifs_pkg::IDX_FLAGS_B)    ||
                   (i == vifs_pkg::IDX_IRQ_STATUS) ||
                   (i == vifs_pkg::IDX_IRQ_MASK));
    endfunction

    function automatic logic is_flag_idx(input logic [7:0] i);
        is_flag_idx = (i == vifs_pkg::IDX_FLAGS_A) ||
                      (i == vifs_pkg::IDX_FLAGS_B);
    endfunction

    // one common flag set serves both copies
    vifs_sticky #(
        .WIDTH   (vifs_pkg::FLAG_W)
    ) u_change_flags (
        .clk_i     (CLK_SYS_I),
        .reset_n_i (RESET_N_I),
        .set_i     (PACKET_CHANGED_I),
        .clr_i     (flag_clr),
        .flags_o   (change_flags)
    );

    // interrupt status sees the same events but clears on its own read
    vifs_sticky #(
        .WIDTH   (vifs_pkg::FLAG_W)
    ) u_irq_status (
        .clk_i     (CLK_SYS_I),
        .reset_n_i (RESET_N_I),
        .set_i     (PACKET_CHANGED_I),
        .clr_i     (stat_clr),
        .flags_o   (irq_status)
    );

    always_comb
    begin
        logic [7:0]  idx;
        logic        rd_done;
        logic [31:0] rval;
        idx     = addr_index(PADDR_I);
        rd_done = 1'b0;
        rval    = 32'h0000_0000;
        st_d    = st_q;

        // fields follow the receiver; a zero top bar means no bar
        st_d.aspect     = ASPECT_CODE_I;
        st_d.scaling    = SCALING_CODE_I;
        st_d.vfc        = VIDEO_FORMAT_CODE_I;
        st_d.repeat_cnt = REPETITION_COUNT_I;
        st_d.topbar     = TOP_BAR_END_LINE_I;

        flag_clr = 7'h00;
        stat_clr = 7'h00;

        case (idx)
            vifs_pkg::IDX_ASPECT:     rval[3:0]  = st_q.aspect;
            vifs_pkg::IDX_SCALING:    rval[1:0]  = st_q.scaling;
            vifs_pkg::IDX_VFC:        rval[6:0]  = st_q.vfc;
            vifs_pkg::IDX_REPEAT:     rval[3:0]  = st_q.repeat_cnt;
            vifs_pkg::IDX_TOPBAR_LO:  rval[7:0]  = st_q.topbar[7:0];
            vifs_pkg::IDX_TOPBAR_HI:  rval[7:0]  = st_q.topbar[15:8];
            vifs_pkg::IDX_FLAGS_A:    rval[6:0]  = change_flags;
            vifs_pkg::IDX_FLAGS_B:    rval[6:0]  = change_flags;
            vifs_pkg::IDX_IRQ_STATUS: rval[6:0]  = irq_status;
            vifs_pkg::IDX_IRQ_MASK:   rval[6:0]  = st_q.irq_mask;
            default:                  rval       = 32'h0000_0000;
        endcase
        if (!addr_ok(PADDR_I))
        begin
            rval = 32'h0000_0000;
        end

        // one wait state: data is sampled in the first access cycle
        if (PSEL_I && PENABLE_I && !st_q.pready)
        begin
            st_d.pready  = 1'b1;
            st_d.pslverr = !addr_ok(PADDR_I);
            st_d.prdata  = PWRITE_I ? 32'h0000_0000 : rval;
        end
        else if (PSEL_I && PENABLE_I && st_q.pready)
        begin
            // completion edge: the transfer takes effect here
            st_d.pready  = 1'b0;
            st_d.pslverr = 1'b0;
            rd_done      = !PWRITE_I && addr_ok(PADDR_I);
            if (PWRITE_I && addr_ok(PADDR_I) &&
                (idx == vifs_pkg::IDX_IRQ_MASK))
            begin
                st_d.irq_mask = PWDATA_I[6:0];
            end
        end
        else
        begin
            st_d.pready  = 1'b0;
            st_d.pslverr = 1'b0;
        end

        // only bits already reported are cleared, so a change landing
        // after the snapshot, up to the completion edge, is kept
        if (rd_done && is_flag_idx(idx))
        begin
            flag_clr = st_q.prdata[6:0];
        end
        if (rd_done && (idx == vifs_pkg::IDX_IRQ_STATUS))
        begin
            stat_clr = st_q.prdata[6:0];
        end

        st_d.irq = |(irq_status & st_q.irq_mask);
    end

    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            st_q          <= '0;
            st_q.irq_mask <= vifs_pkg::MASK_RST;
            st_q.topbar   <= vifs_pkg::TOPBAR_NONE;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign PRDATA_O  = st_q.prdata;
    assign PREADY_O  = st_q.pready;
    assign PSLVERR_O = st_q.pslverr;
    assign IRQ_O     = st_q.irq;

endmodule // vifs_regs

// >>> vifs_regs_props.sv
`timescale 1ns/1ps

module vifs_regs_props (
    input wire logic        CLK_SYS_I,
    input wire logic        RESET_N_I,
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [6:0]  VIDEO_FORMAT_CODE_I,
    input wire logic [6:0]  PACKET_CHANGED_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic        PREADY_O,
    input wire logic        PSLVERR_O,
    input wire logic        IRQ_O
);
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (!RESET_N_I);
    sequence qt;
        PACKET_CHANGED_I == 7'h00;
    endsequence
    // completed read of either flag copy
    sequence frd;
        PREADY_O && !PWRITE_I && (PADDR_I | 12'h020) == 12'h23C;
    endsequence
    chk_ready_one: assert property (
        PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O ##1 !PREADY_O)
        else $error("ready timing wrong");
    chk_vfc_read: assert property (
        PREADY_O && !PWRITE_I && PADDR_I == 12'h210
        |-> PRDATA_O == {25'h0, $past(VIDEO_FORMAT_CODE_I, 2)})
        else $error("format code read wrong");
    chk_bad_addr: assert property (
        PREADY_O && PADDR_I == 12'h3FC |-> PSLVERR_O && PRDATA_O == 32'h0)
        else $error("unmapped access not refused");
    chk_flag_clean: assert property (
        frd |-> PRDATA_O[31:7] == 25'h0 && !PSLVERR_O)
        else $error("flag read upper bits or error set");
    chk_flag_clear: assert property (
        qt ##1 (frd ##0 qt) ##1 qt ##2 frd |-> PRDATA_O[6:0] == 7'h00)
        else $error("flags not cleared by read");
    chk_set_wins: assert property (
        (frd ##0 PACKET_CHANGED_I[0]) ##3 frd |-> PRDATA_O[0])
        else $error("change lost during clearing read");
    chk_irq_cause: assert property (
        $rose(IRQ_O) |-> $past(PACKET_CHANGED_I, 2) != 7'h00
        || $past(PREADY_O && PWRITE_I && PADDR_I == 12'h3C4, 2))
        else $error("interrupt rose without cause");
    chk_irq_drop: assert property (
        qt ##1 (PREADY_O && !PWRITE_I && PADDR_I == 12'h3C0 ##0 qt) ##1 qt
        |=> !IRQ_O) else $error("interrupt stayed after clear");
endmodule // vifs_regs_props

// >>> vifs_regs_tb_top.sv
`timescale 1ns/1ps

module vifs_regs_tb_top;
    logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0;
    logic        pwr = 1'b0, pready, pslverr, irq, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [6:0]  vfc = 7'h00, pc = 7'h00;
    logic [3:0]  asp = 4'h0, rep = 4'h0;
    logic [1:0]  sc = 2'h0;
    logic [15:0] tbar = 16'h0000;
    int          error_cnt, comparisons, flags, st;
    vifs_regs u_dut (.CLK_SYS_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .ASPECT_CODE_I(asp), .SCALING_CODE_I(sc), .VIDEO_FORMAT_CODE_I(vfc),
        .REPETITION_COUNT_I(rep), .TOP_BAR_END_LINE_I(tbar),
        .PACKET_CHANGED_I(pc), .IRQ_O(irq));
    task automatic complete_run();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // p is pulsed in the completion cycle, after the read snapshot
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [6:0] p);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do
        begin
            @(posedge clk);
            if (p != 7'h00)
                pc <= pready ? 7'h00 : p;
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        pen <= 1'b0;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, 7'h00);
        chk(rd, e);
    endtask
    task automatic rdf(input logic [11:0] a, input logic [6:0] p);
        apb(1'b0, a, 32'h0, p);
        chk(rd, 32'(flags));
        flags = p;
        st |= p;
    endtask
    task automatic idle();
        psel <= 1'b0;
        @(posedge clk);
    endtask
    task automatic pulse(input logic [6:0] p);
        pc <= p;
        @(posedge clk);
        pc <= 7'h00;
        flags |= p;
        st |= p;
        @(posedge clk);
    endtask
    initial
    begin
        forever #5 clk = ~clk;
    end
    initial
    begin
        #200us;
        error_cnt++;
        complete_run();
    end
    initial
    begin
        void'($urandom(18727));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rdf(12'h21C, 7'h00);
        for (int i = 0; i < 4; i++)
        begin
            idle();
            asp <= 4'h8 + 4'(i);
            sc <= 2'(i);
            vfc <= 7'($urandom);
            rep <= 4'($urandom % 10);
            tbar <= (i == 0) ? 16'h0000 : 16'($urandom);
            @(posedge clk);
            rdc(12'h208, 32'(asp));
            rdc(12'h20C, 32'(sc));
            rdc(12'h210, 32'(vfc));
            rdc(12'h214, 32'(rep));
            rdc(12'h218, 32'(tbar[7:0]));
            rdc(12'h220, 32'(tbar[15:8]));
        end
        apb(1'b1, 12'h210, 32'h7F, 7'h00);
        chk(32'(er), 32'h0);
        rdc(12'h210, 32'(vfc));
        $display("field test done");
        for (int k = 0; k < 7; k++)
        begin
            idle();
            pulse(7'(1 << k));
            rdf(k[0] ? 12'h23C : 12'h21C, 7'h00);
            rdf(k[0] ? 12'h21C : 12'h23C, 7'h00);
        end
        idle();
        pulse(7'h01);
        rdf(12'h21C, 7'h41);
        rdf(12'h23C, 7'h00);
        apb(1'b0, 12'h3FC, 32'h0, 7'h00);
        chk({er, rd[30:0]}, 32'h80000000);
        $display("flag test done");
        rdc(12'h3C0, 32'(st));
        idle();
        pulse(7'h05);
        apb(1'b1, 12'h3C4, 32'h4, 7'h00);
        idle();
        @(posedge clk);
        chk(32'(irq), 32'h1);
        rdc(12'h3C4, 32'h4);
        rdc(12'h3C0, 32'h5);
        idle();
        @(posedge clk);
        chk(32'(irq), 32'h0);
        pulse(7'h02);
        @(posedge clk);
        chk(32'(irq), 32'h0);
        $display("irq test done");
        complete_run();
    end
endmodule // vifs_regs_tb_top

bind vifs_regs vifs_regs_props u_props (.CLK_SYS_I, .RESET_N_I, .PSEL_I,
    .PENABLE_I, .PWRITE_I, .PADDR_I, .VIDEO_FORMAT_CODE_I,
    .PACKET_CHANGED_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .IRQ_O);

// >>> vifs_sticky.sv
`timescale 1ns/1ps

// sticky flag set; a set in the same cycle as a clear wins
module vifs_sticky #(
    parameter int WIDTH = 7
) (
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    input  wire logic [WIDTH-1:0] set_i,
    input  wire logic [WIDTH-1:0] clr_i,
    output logic      [WIDTH-1:0] flags_o
);

    typedef struct packed {
        logic [WIDTH-1:0] flags;
    } vifs_sticky_t;

    vifs_sticky_t st_q;
    vifs_sticky_t st_d;

    always_comb
    begin
        st_d       = st_q;
        st_d.flags = (st_q.flags & ~clr_i) | set_i;
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign flags_o = st_q.flags;

endmodule // vifs_sticky
